// [anr_pkg.sv]
// Package of register offsets, field positions and reset values for the next page register bank
package anr_pkg;
    // ****************************************
    // Register indices (management register numbers)
    // ****************************************
    localparam logic [4:0] ANR_REG_CONTROL = 5'h00;
    localparam logic [4:0] ANR_REG_STATUS = 5'h01;
    localparam logic [4:0] ANR_REG_ADVERT = 5'h04;
    localparam logic [4:0] ANR_REG_PARTNER = 5'h05;
    localparam logic [4:0] ANR_REG_EXPANSION = 5'h06;
    localparam logic [4:0] ANR_REG_NP_TX = 5'h07;
    localparam logic [4:0] ANR_REG_NP_RX = 5'h08;
    localparam logic [4:0] ANR_REG_EXT_STATUS = 5'h0F;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int ANR_BIT_MORE_PAGES = 15;
    localparam int ANR_BIT_ACK = 14;
    localparam int ANR_BIT_FORMATTED = 13;
    localparam int ANR_BIT_COMPLY = 12;
    localparam int ANR_BIT_TOGGLE = 11;
    localparam int ANR_BIT_AN_COMPLETE = 5;
    localparam int ANR_BIT_AN_ENABLE = 12;
    localparam int ANR_BIT_AN_RESTART = 9;
    localparam int ANR_BIT_NP_ABLE = 2;
    localparam int ANR_BIT_PAGE_RX = 1;

    // Writable bits of the advertisement: 15, 13:12, 8:7, 6, 5
    localparam logic [15:0] ANR_ADVERT_WMASK = 16'hB1E0;
    // Partner base page adds acknowledge at bit 14
    localparam logic [15:0] ANR_PARTNER_MASK = 16'hF1E0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] ANR_ADVERT_RESET = 16'h0060;
    localparam logic [15:0] ANR_ZERO16 = 16'h0000;
    localparam logic [15:0] ANR_CONTROL_RESET = 16'h1000;
    localparam logic [15:0] ANR_STATUS_CAPS = 16'h0108;
    localparam logic [15:0] ANR_EXT_STATUS_CAPS = 16'hC000;
    localparam logic [10:0] ANR_NULL_MESSAGE = 11'h001;
endpackage

// [anr_page_shaper.sv]
// Shapes an outgoing next page: toggle, acknowledge clear and null message substitution
`timescale 1ns/1ps
module anr_page_shaper (
    input wire logic [15:0] i_np_tx_word,
    input wire logic i_have_page,
    input wire logic i_prev_toggle,
    input wire logic i_code_allowed,
    output logic [15:0] o_page
);
    import anr_pkg::*;

    // Without a loaded page, or with a reserved code on a message page, send a null message page, last
    always_comb begin
        if (i_have_page && (i_code_allowed || !i_np_tx_word[ANR_BIT_FORMATTED])) begin
            o_page = i_np_tx_word;
        end else begin
            o_page = {5'b00101, ANR_NULL_MESSAGE};
        end
        o_page[ANR_BIT_ACK] = 1'b0;
        o_page[ANR_BIT_TOGGLE] = ~i_prev_toggle;
    end
endmodule

// [anr_regs.sv]
// Management register bank and next page exchange sequencing for the negotiation block
`timescale 1ns/1ps
module anr_regs #(
    parameter bit NP_SUPPORTED = 1'b1
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    // Management access
    input wire logic [4:0] i_mgmt_addr,
    input wire logic i_mgmt_wr,
    input wire logic i_mgmt_rd,
    input wire logic [15:0] i_mgmt_wdata,
    output logic [15:0] o_mgmt_rdata,
    output logic o_mgmt_rvalid,
    // Link page exchange
    input wire logic i_rx_page_valid,
    input wire logic [15:0] i_rx_page,
    input wire logic i_page_acked,
    input wire logic i_code_allowed,
    input wire logic i_can_comply,
    output logic [15:0] o_tx_page,
    output logic o_tx_page_valid,
    output logic o_np_exchange,
    output logic o_an_complete,
    output logic o_an_enable,
    output logic o_an_restart,
    output logic o_page_loaded_indication
);
    import anr_pkg::*;

    typedef enum logic [1:0] {
        ANR_ST_BASE,
        ANR_ST_NEXT,
        ANR_ST_DONE
    } anr_state_t;

    // ****************************************
    // Storage
    // ****************************************
    anr_state_t state_reg;
    logic [15:0] control_reg;
    logic [15:0] advert_reg;
    logic [15:0] partner_reg;
    logic [15:0] np_tx_reg;
    logic [15:0] np_rx_reg;
    logic page_rx_reg;
    logic complete_reg;
    logic loaded_reg;
    logic last_toggle_reg;
    logic local_done_reg;
    logic partner_done_reg;
    logic [15:0] shaped_page;
    logic [15:0] tx_next;
    logic wr_advert;
    logic wr_control;
    logic wr_np_tx;
    logic rd_expansion;
    logic store_base;
    logic store_next;

    // Decode helper used by both the write and read paths
    function automatic logic hit(input logic [4:0] addr, input logic [4:0] reg_idx);
        hit = (addr == reg_idx);
    endfunction

    assign wr_control = i_mgmt_wr && hit(i_mgmt_addr, ANR_REG_CONTROL);
    assign wr_advert = i_mgmt_wr && hit(i_mgmt_addr, ANR_REG_ADVERT);
    assign wr_np_tx = i_mgmt_wr && NP_SUPPORTED && hit(i_mgmt_addr, ANR_REG_NP_TX);
    assign rd_expansion = i_mgmt_rd && hit(i_mgmt_addr, ANR_REG_EXPANSION);
    assign store_base = i_rx_page_valid && (state_reg == ANR_ST_BASE);
    assign store_next = i_rx_page_valid && (state_reg == ANR_ST_NEXT);

    // ****************************************
    // Control register; restart bit self-clears
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            control_reg <= ANR_CONTROL_RESET;
        end else if (i_clk_en) begin
            if (wr_control) begin
                control_reg <= i_mgmt_wdata;
            end else begin
                control_reg[ANR_BIT_AN_RESTART] <= 1'b0;
            end
        end
    end

    // Advertisement keeps only its writable fields; reserved bits stay zero
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            advert_reg <= ANR_ADVERT_RESET;
        end else if (i_clk_en && wr_advert) begin
            advert_reg <= i_mgmt_wdata & ANR_ADVERT_WMASK;
        end
    end

    // Partner pages come only from the link; management writes are dropped
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            partner_reg <= ANR_ZERO16;
            np_rx_reg <= ANR_ZERO16;
        end else if (i_clk_en) begin
            if (store_base) begin
                partner_reg <= i_rx_page & ANR_PARTNER_MASK;
            end
            if (store_next && NP_SUPPORTED) begin
                np_rx_reg <= i_rx_page;
            end
        end
    end

    // Page received: set wins over a same-cycle read clear
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            page_rx_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (store_base || store_next) begin
                page_rx_reg <= 1'b1;
            end else if (rd_expansion) begin
                page_rx_reg <= 1'b0;
            end
        end
    end

    // Next page transmit word; comply flag is taken from the local ability to act at each write
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            np_tx_reg <= ANR_ZERO16;
        end else if (i_clk_en) begin
            if (wr_np_tx) begin
                np_tx_reg <= i_mgmt_wdata;
            end
            np_tx_reg[ANR_BIT_COMPLY] <= wr_np_tx ? i_can_comply : np_tx_reg[ANR_BIT_COMPLY];
        end
    end

    // Page loaded: a write sets it, taking the page clears it; write wins
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            loaded_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (wr_np_tx) begin
                loaded_reg <= 1'b1;
            end else if (state_reg == ANR_ST_NEXT && i_page_acked) begin
                loaded_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Page exchange sequencing
    // ****************************************
    anr_page_shaper u_shaper (
        .i_np_tx_word(np_tx_reg),
        .i_have_page(loaded_reg),
        .i_prev_toggle(last_toggle_reg),
        .i_code_allowed(i_code_allowed),
        .o_page(shaped_page)
    );

    // Restart or disable returns to base page; exchange needs both next page bits
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= ANR_ST_BASE;
            complete_reg <= 1'b0;
            last_toggle_reg <= 1'b0;
            local_done_reg <= 1'b0;
            partner_done_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (control_reg[ANR_BIT_AN_RESTART] || !control_reg[ANR_BIT_AN_ENABLE]) begin
                state_reg <= ANR_ST_BASE;
                complete_reg <= 1'b0;
                local_done_reg <= 1'b0;
                partner_done_reg <= 1'b0;
            end else begin
                unique case (state_reg)
                    ANR_ST_BASE: begin
                        if (i_rx_page_valid) begin
                            last_toggle_reg <= advert_reg[ANR_BIT_TOGGLE];
                            if (NP_SUPPORTED && advert_reg[ANR_BIT_MORE_PAGES]
                                && i_rx_page[ANR_BIT_MORE_PAGES]) begin
                                state_reg <= ANR_ST_NEXT;
                            end else begin
                                state_reg <= ANR_ST_DONE;
                                complete_reg <= 1'b1;
                            end
                        end
                    end
                    ANR_ST_NEXT: begin
                        if (i_page_acked) begin
                            last_toggle_reg <= shaped_page[ANR_BIT_TOGGLE];
                            local_done_reg <= !shaped_page[ANR_BIT_MORE_PAGES];
                        end
                        if (i_rx_page_valid) begin
                            partner_done_reg <= !i_rx_page[ANR_BIT_MORE_PAGES];
                        end
                        if (local_done_reg && partner_done_reg) begin
                            state_reg <= ANR_ST_DONE;
                            complete_reg <= 1'b1;
                        end
                    end
                    ANR_ST_DONE: begin
                        complete_reg <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Transmit word: shaped next page during the next page exchange, base page in the other states
    always_comb begin
        tx_next = advert_reg;
        if (state_reg == ANR_ST_NEXT) begin
            tx_next = shaped_page;
        end
    end

    // Registered link outputs
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tx_page <= ANR_ZERO16;
            o_tx_page_valid <= 1'b0;
            o_np_exchange <= 1'b0;
            o_an_complete <= 1'b0;
            o_an_enable <= 1'b0;
            o_an_restart <= 1'b0;
            o_page_loaded_indication <= 1'b0;
        end else if (i_clk_en) begin
            o_tx_page <= tx_next;
            o_tx_page_valid <= (state_reg != ANR_ST_DONE) && control_reg[ANR_BIT_AN_ENABLE];
            o_np_exchange <= (state_reg == ANR_ST_NEXT);
            o_an_complete <= complete_reg;
            o_an_enable <= control_reg[ANR_BIT_AN_ENABLE];
            o_an_restart <= control_reg[ANR_BIT_AN_RESTART];
            o_page_loaded_indication <= loaded_reg;
        end
    end

    // ****************************************
    // Read path; one cycle latency, unmapped reads zero
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_mgmt_rdata <= ANR_ZERO16;
            o_mgmt_rvalid <= 1'b0;
        end else if (i_clk_en) begin
            o_mgmt_rvalid <= i_mgmt_rd;
            o_mgmt_rdata <= ANR_ZERO16;
            if (i_mgmt_rd) begin
                unique case (i_mgmt_addr)
                    ANR_REG_CONTROL: o_mgmt_rdata <= control_reg;
                    ANR_REG_STATUS: begin
                        o_mgmt_rdata <= ANR_STATUS_CAPS;
                        o_mgmt_rdata[ANR_BIT_AN_COMPLETE] <= complete_reg;
                    end
                    ANR_REG_ADVERT: o_mgmt_rdata <= advert_reg;
                    ANR_REG_PARTNER: o_mgmt_rdata <= partner_reg;
                    ANR_REG_EXPANSION: begin
                        o_mgmt_rdata[ANR_BIT_NP_ABLE] <= NP_SUPPORTED;
                        o_mgmt_rdata[ANR_BIT_PAGE_RX] <= page_rx_reg;
                    end
                    ANR_REG_NP_TX: o_mgmt_rdata <= NP_SUPPORTED ? np_tx_reg : ANR_ZERO16;
                    ANR_REG_NP_RX: o_mgmt_rdata <= NP_SUPPORTED ? np_rx_reg : ANR_ZERO16;
                    ANR_REG_EXT_STATUS: o_mgmt_rdata <= ANR_EXT_STATUS_CAPS;
                    default: o_mgmt_rdata <= ANR_ZERO16;
                endcase
            end
        end
    end
endmodule

// [anr_regs_asserts.sv]
// Port checker of the next page register bank
`timescale 1ns/1ps
module anr_regs_asserts #(
    parameter bit NP_SUPPORTED = 1'b1
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    input wire logic [4:0] i_mgmt_addr,
    input wire logic i_mgmt_wr,
    input wire logic i_mgmt_rd,
    input wire logic [15:0] i_mgmt_wdata,
    input wire logic [15:0] o_mgmt_rdata,
    input wire logic o_mgmt_rvalid,
    input wire logic i_rx_page_valid,
    input wire logic [15:0] i_rx_page,
    input wire logic i_page_acked,
    input wire logic i_code_allowed,
    input wire logic i_can_comply,
    input wire logic [15:0] o_tx_page,
    input wire logic o_tx_page_valid,
    input wire logic o_np_exchange,
    input wire logic o_an_complete,
    input wire logic o_an_enable,
    input wire logic o_an_restart,
    input wire logic o_page_loaded_indication
);
    import anr_pkg::*;
    // ****
    // Management and page exchange properties
    // ****
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);
    a_read_answer: assert property (i_mgmt_rd && i_clk_en |=> o_mgmt_rvalid)
        else $error("read not answered");
    a_no_stray: assert property (!i_mgmt_rd && i_clk_en |=> !o_mgmt_rvalid)
        else $error("answer without read");
    a_idle_rdata: assert property (!o_mgmt_rvalid |-> o_mgmt_rdata == 16'h0000)
        else $error("read data not zero when idle");
    a_advert_reserved: assert property (o_mgmt_rvalid && $past(i_mgmt_addr) == ANR_REG_ADVERT
        |-> (o_mgmt_rdata & 16'h4E1F) == 16'h0000) else $error("advert reserved bit set");
    a_expansion_bits: assert property (o_mgmt_rvalid && $past(i_mgmt_addr) == ANR_REG_EXPANSION
        |-> o_mgmt_rdata[15:3] == 13'h0000 && !o_mgmt_rdata[0] && o_mgmt_rdata[2] == NP_SUPPORTED)
        else $error("expansion fixed bits wrong");
    a_np_entry: assert property ($rose(o_np_exchange) |-> $past(o_tx_page[15]))
        else $error("next pages without local advert");
    a_first_toggle: assert property ($rose(o_np_exchange) |-> o_tx_page[11] != $past(o_tx_page[11]))
        else $error("first toggle not inverted");
    a_loaded_on_write: assert property (i_clk_en && i_mgmt_wr && i_mgmt_addr == ANR_REG_NP_TX
        && !i_page_acked && NP_SUPPORTED |=> ##1 o_page_loaded_indication) else $error("page not loaded");
    a_complete_status: assert property (o_mgmt_rvalid && $past(i_mgmt_addr) == ANR_REG_STATUS
        && o_mgmt_rdata[5] |-> ##[0:2] o_an_complete) else $error("complete output missing");
    // Main scenarios reached
    c_np_entry: cover property ($rose(o_np_exchange));
    c_complete: cover property ($rose(o_an_complete));
    c_page_taken: cover property (i_page_acked && o_page_loaded_indication);
endmodule

// [anr_lp_model.sv]
// Link partner model that sends pages and acknowledges ours
`timescale 1ns/1ps
module anr_lp_model (
    input wire logic i_core_clk,
    input wire logic i_tx_page_valid,
    output logic o_rx_page_valid,
    output logic [15:0] o_rx_page,
    output logic o_page_acked
);
    logic tog;
    // ****
    // Page traffic
    // ****
    initial begin
        o_rx_page_valid = 1'b0;
        o_rx_page = 16'h0000;
        o_page_acked = 1'b0;
        tog = 1'b0;
    end
    // One page pulse; the word is inverted after it, as nothing holds the line
    task automatic send(input logic [15:0] w);
        @(negedge i_core_clk);
        o_rx_page = w;
        o_rx_page_valid = 1'b1;
        @(negedge i_core_clk);
        o_rx_page_valid = 1'b0;
        o_rx_page = ~w;
    endtask
    // Base page; our first toggle opposes its bit 11
    task automatic base(input logic [15:0] w);
        tog = ~w[11];
        send(w);
    endtask
    // Message page, acknowledge and comply set, code as the caller gives it
    task automatic np_page(input logic more, input logic [10:0] code, output logic [15:0] w);
        w = {more, 1'b1, 1'b1, 1'b1, tog, code};
        tog = ~tog;
        send(w);
    endtask
    // Take the page now on offer
    task automatic ack();
        @(negedge i_core_clk);
        o_page_acked = i_tx_page_valid;
        @(negedge i_core_clk);
        o_page_acked = 1'b0;
    endtask
endmodule

// [anr_regs_tb.sv]
// Self-checking bench of the next page register bank
`timescale 1ns/1ps
module anr_regs_tb;
    import anr_pkg::*;
    logic i_core_clk, i_arst_n, i_clk_en, i_mgmt_wr, i_mgmt_rd, o_mgmt_rvalid, i_rx_page_valid;
    logic i_page_acked, i_code_allowed, i_can_comply, o_tx_page_valid, o_np_exchange, o_an_complete;
    logic o_an_enable, o_an_restart, o_page_loaded_indication, tog;
    logic [4:0] i_mgmt_addr;
    logic [15:0] i_mgmt_wdata, o_mgmt_rdata, i_rx_page, o_tx_page, v, w;
    int fail_count = 0;
    int checks_done = 0;
    int seed = 32'h2589;
    anr_regs dut (.*);
    anr_lp_model lp (.i_core_clk(i_core_clk), .i_tx_page_valid(o_tx_page_valid), .o_rx_page_valid(i_rx_page_valid),
        .o_rx_page(i_rx_page), .o_page_acked(i_page_acked));
    // ****
    // Clock, tasks and checks
    // ****
    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic mwr(input logic [4:0] a, input logic [15:0] d);
        @(negedge i_core_clk);
        i_mgmt_addr = a;
        i_mgmt_wdata = d;
        i_mgmt_wr = 1'b1;
        @(negedge i_core_clk);
        i_mgmt_wr = 1'b0;
    endtask
    // Answer comes one cycle after the strobe
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
        @(negedge i_core_clk);
        i_mgmt_addr = a;
        i_mgmt_rd = 1'b1;
        @(negedge i_core_clk);
        i_mgmt_rd = 1'b0;
        chk("rvalid", {15'h0000, o_mgmt_rvalid}, 16'h0001);
        chk("read data", o_mgmt_rdata, e);
    endtask
    // Expected next page word, acknowledge bit left out
    function automatic logic [15:0] page(input logic m, f, c, t, input logic [10:0] code);
        return {m, 1'b0, f, c, t, code};
    endfunction
    task automatic results();
        $display("Checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Cut a hang short
    initial begin
        #(8 * 3000);
        fail_count++;
        results();
    end
    // Main sequence
    initial begin
        {i_arst_n, i_mgmt_wr, i_mgmt_rd, i_mgmt_addr, i_mgmt_wdata} = '0;
        {i_clk_en, i_code_allowed, i_can_comply} = 3'h7;
        repeat (8) @(negedge i_core_clk);
        i_arst_n = 1'b1;
        rd_chk(ANR_REG_CONTROL, ANR_CONTROL_RESET);
        chk("an enable", {15'h0000, o_an_enable}, 16'h0001);
        rd_chk(ANR_REG_ADVERT, ANR_ADVERT_RESET);
        rd_chk(ANR_REG_EXT_STATUS, ANR_EXT_STATUS_CAPS);
        rd_chk(ANR_REG_STATUS, ANR_STATUS_CAPS);
        rd_chk(5'h02, 16'h0000);
        @(negedge i_core_clk);
        i_clk_en = 1'b0;
        i_mgmt_rd = 1'b1;
        @(negedge i_core_clk);
        chk("frozen rvalid", {15'h0000, o_mgmt_rvalid}, 16'h0000);
        {i_mgmt_rd, i_clk_en} = 2'h1;
        mwr(ANR_REG_EXPANSION, 16'hFFFF);
        rd_chk(ANR_REG_EXPANSION, 16'h0004);
        $display("reset values done");
        repeat (4) begin
            v = $random(seed);
            mwr(ANR_REG_ADVERT, v);
            rd_chk(ANR_REG_ADVERT, v & 16'hB1E0);
        end
        $display("advert done");
        mwr(ANR_REG_ADVERT, 16'h81E0);
        lp.base(16'hC1A0);
        repeat (3) @(negedge i_core_clk);
        chk("np exchange", {15'h0000, o_np_exchange}, 16'h0001);
        tog = 1'b1;
        chk("null page", o_tx_page & 16'hAFFF, page(0, 1, 0, tog, 11'h001));
        mwr(ANR_REG_PARTNER, 16'hFFFF);
        rd_chk(ANR_REG_EXPANSION, 16'h0006);
        rd_chk(ANR_REG_EXPANSION, 16'h0004);
        rd_chk(ANR_REG_PARTNER, 16'hC1A0);
        $display("base page done");
        mwr(ANR_REG_NP_TX, 16'hA005);
        @(negedge i_core_clk);
        chk("loaded", {15'h0000, o_page_loaded_indication}, 16'h0001);
        repeat (2) @(negedge i_core_clk);
        chk("message page", o_tx_page & 16'hBFFF, page(1, 1, 1, tog, 11'h005));
        lp.ack();
        tog = ~tog;
        repeat (2) @(negedge i_core_clk);
        chk("taken", {15'h0000, o_page_loaded_indication}, 16'h0000);
        lp.np_page(1'b1, 11'h005, w);
        rd_chk(ANR_REG_EXPANSION, 16'h0006);
        rd_chk(ANR_REG_NP_RX, w);
        {i_code_allowed, i_can_comply} = 2'h0;
        mwr(ANR_REG_NP_TX, 16'hA7FF);
        repeat (2) @(negedge i_core_clk);
        chk("reserved code", o_tx_page & 16'hAFFF, page(0, 1, 0, tog, 11'h001));
        i_code_allowed = 1'b1;
        v = $random(seed);
        mwr(ANR_REG_NP_TX, {5'h00, v[10:0]});
        repeat (2) @(negedge i_core_clk);
        chk("unformatted", o_tx_page & 16'hBFFF, page(0, 0, 0, tog, v[10:0]));
        lp.ack();
        $display("next pages done");
        lp.np_page(1'b0, 11'h001, w);
        for (int i = 0; i < 8 && o_an_complete !== 1'b1; i++) @(negedge i_core_clk);
        chk("complete", {15'h0000, o_an_complete}, 16'h0001);
        chk("tx stopped", {15'h0000, o_tx_page_valid}, 16'h0000);
        rd_chk(ANR_REG_STATUS, ANR_STATUS_CAPS | 16'h0020);
        // Restart drops completion and pulses the restart output
        mwr(ANR_REG_CONTROL, 16'h1200);
        @(negedge i_core_clk);
        chk("restart", {15'h0000, o_an_restart}, 16'h0001);
        @(negedge i_core_clk);
        chk("complete cleared", {15'h0000, o_an_complete}, 16'h0000);
        $display("completion done");
        results();
    end
endmodule
bind anr_regs anr_regs_asserts #(.NP_SUPPORTED(NP_SUPPORTED)) u_chk (.*);
